// file: include/dmas_pkg.sv
// Package for the differential mux and converter sequencer controller.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
package dmas_pkg;
    // Clock and pin timing.
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCLK_PERIOD_NS = 200;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int SETTLE_NS      = 700;
    localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RATE_CHG_KSPS  = 625;
    localparam int RATE_SAME_KSPS = 1250;
    localparam int PACE_CHG_CYC   = (1000000 / RATE_CHG_KSPS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PACE_SAME_CYC  = (1000000 / RATE_SAME_KSPS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONVERSION_START_N_LOW_CYC = 2;
    localparam int RD_LOW_CYC     = 4;
    // Selection word and data widths.
    localparam int SEL_BITS  = 4;
    localparam int CH_BITS   = 3;
    localparam int NUM_CH    = 8;
    localparam int DATA_BITS = 12;
    // Register offsets.
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_SEQ     = 8'h04;
    localparam logic [7:0] REG_COUNT   = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0c;
    localparam logic [7:0] REG_DATA    = 8'h10;
    localparam logic [7:0] REG_IRQ_ST  = 8'h14;
    localparam logic [7:0] REG_IRQ_EN  = 8'h18;
    localparam logic [7:0] REG_IRQ_CLR = 8'h1c;
    // Field positions.
    localparam int CTRL_START_BIT  = 0;
    localparam int SEQ_LEN_LSB     = 24;
    localparam int SEQ_WIDTH       = 27;
    localparam int STAT_SHIFT_BIT  = 1;
    localparam int STAT_CH_LSB     = 4;
    localparam int STAT_CNT_LSB    = 16;
    localparam int DATA_CH_LSB     = 16;
    localparam int IRQ_SAMPLE_BIT  = 0;
    localparam int IRQ_DONE_BIT    = 1;
    localparam int IRQ_BITS        = 2;
    // Reset values and response codes.
    localparam logic [SEQ_WIDTH-1:0] SEQ_RESET = 27'h7fac688;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV, ST_READ} dmas_state_e;

    typedef struct packed {
        dmas_state_e             state;
        logic                    cs_n;
        logic                    conversion_start_n_n;
        logic                    rd_n;
        logic                    sel;
        logic                    sclk;
        logic                    sdata;
        logic                    sh_busy;
        logic [SEL_BITS-1:0]     sh_word;
        logic [2:0]              sh_bit;
        logic [1:0]              sh_ph;
        logic [4:0]              settle;
        logic [7:0]              since;
        logic                    changed;
        logic [2:0]              cnt;
        logic [CH_BITS-1:0]      idx;
        logic [CH_BITS-1:0]      cur_ch;
        logic [CH_BITS-1:0]      conv_ch;
        logic [15:0]             remain;
        logic [15:0]             done_cnt;
        logic [DATA_BITS-1:0]    data;
        logic [CH_BITS-1:0]      data_ch;
        logic                    b1;
        logic                    b2;
        logic                    b3;
        logic [DATA_BITS-1:0]    d1;
        logic [DATA_BITS-1:0]    d2;
        logic [SEQ_WIDTH-1:0]    seq_cfg;
        logic [15:0]             count_cfg;
        logic [IRQ_BITS-1:0]     irq_st;
        logic [IRQ_BITS-1:0]     irq_en;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
    } dmas_state_s;

    // Selection word for one channel pair: enable flag above the channel index.
    function automatic logic [SEL_BITS-1:0] sel_word(input logic [CH_BITS-1:0] ch);
        sel_word = {1'b1, ch};
    endfunction

    // Channel held at one position of the channel order list.
    function automatic logic [CH_BITS-1:0] order_ch(input logic [SEQ_WIDTH-1:0] cfg,
                                                   input logic [CH_BITS-1:0]   pos);
        order_ch = cfg[int'(pos) * CH_BITS +: CH_BITS];
    endfunction

    // Merge a written word into a register under its byte strobes.
    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                old[8*i +: 8] = wd[8*i +: 8];
            end
        end
        apply_strb = old;
    endfunction
endpackage

// file: logic/dmas_ctrl.sv
// Controller for a two-multiplexer differential acquisition front end and its converter.
// Assumes the converter's busy and data pins are asynchronous and an AXI4-Lite master.
`timescale 1ns/1ps

module dmas_ctrl
    import dmas_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      mux_select_n,
    output logic                      mux_sclk,
    output logic                      mux_data,
    output logic                      conversion_start_n,
    output logic                      adc_cs_n,
    output logic                      adc_rd_n,
    input  wire logic                 adc_busy,
    input  wire logic [DATA_BITS-1:0] adc_data,
    output logic                      irq
);
    localparam logic [1:0] PH_LAST  = 2'(2 * SCLK_HALF_CYC - 1);
    localparam logic [1:0] PH_HIGH  = 2'(SCLK_HALF_CYC);
    localparam logic [2:0] BIT_LAST = 3'(SEL_BITS - 1);

    dmas_state_s           q;
    dmas_state_s           n;
    logic                  busy_rise;
    logic                  wr_go;
    logic [7:0]            wa;
    logic [7:0]            ra;
    logic [IRQ_BITS-1:0]   set_ev;
    logic [CH_BITS-1:0]    nidx;
    logic [CH_BITS-1:0]    nch;
    logic [31:0]           rword;
    logic [31:0]           merged;

    // Starts shifting a selection word onto the shared mux pins.
    function automatic dmas_state_s launch(input dmas_state_s s, input logic [CH_BITS-1:0] ch);
        s.sh_busy = 1'b1;
        s.sh_word = sel_word(ch);
        s.sh_bit  = 3'h0;
        s.sh_ph   = 2'h0;
        s.sel     = 1'b1;
        s.sclk    = 1'b0;
        s.sdata   = s.sh_word[SEL_BITS-1];
        return s;
    endfunction

    // Ready handshakes are combinational; valid, response and data outputs come from the state register.
    assign wr_go          = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign s_axi_awready  = wr_go;
    assign s_axi_wready   = wr_go;
    assign s_axi_arready  = !q.rvalid;
    assign s_axi_bvalid   = q.bvalid;
    assign s_axi_bresp    = q.bresp;
    assign s_axi_rvalid   = q.rvalid;
    assign s_axi_rresp    = q.rresp;
    assign s_axi_rdata    = q.rdata;
    assign mux_select_n   = q.sel;
    assign mux_sclk       = q.sclk;
    assign mux_data       = q.sdata; // One data line feeds both muxes.
    assign conversion_start_n = q.conversion_start_n_n;
    assign adc_cs_n       = q.cs_n;
    assign adc_rd_n       = q.rd_n;
    assign irq            = |(q.irq_st & q.irq_en);
    assign busy_rise      = q.b2 && !q.b3;
    assign wa             = {s_axi_awaddr[7:2], 2'h0};
    assign ra             = {s_axi_araddr[7:2], 2'h0};

    // Next-state logic: pin synchronisers, shift engine, sequencer and register slave.
    always_comb begin
        n      = q;
        set_ev = '0;
        nidx   = '0;
        nch    = '0;
        rword  = '0;
        merged = apply_strb(32'h0, s_axi_wdata, s_axi_wstrb);
        n.b1 = adc_busy;
        n.b2 = q.b1;
        n.b3 = q.b2;
        n.d1 = adc_data;
        n.d2 = q.d1;
        if (q.since != 8'hff) begin
            n.since = q.since + 8'h01;
        end
        if (q.settle != 5'h1f) begin
            n.settle = q.settle + 5'h01;
        end
        // Serial shift: data changes on clock fall, mux samples on clock rise.
        if (q.sh_busy) begin
            if (q.sh_ph == PH_LAST) begin
                n.sh_ph = 2'h0;
                n.sclk  = 1'b0;
                if (q.sh_bit == BIT_LAST) begin
                    n.sh_busy = 1'b0;
                    n.sel     = 1'b0; // Falling select latches the word.
                    n.settle  = 5'h00;
                end else begin
                    n.sh_bit  = q.sh_bit + 3'h1;
                    n.sh_word = {q.sh_word[SEL_BITS-2:0], 1'b0};
                    n.sdata   = q.sh_word[SEL_BITS-2];
                end
            end else begin
                n.sh_ph = q.sh_ph + 2'h1;
                n.sclk  = (n.sh_ph >= PH_HIGH);
            end
        end
        // Conversion sequencer.
        case (q.state)
            ST_IDLE: begin
                if (wr_go && wa == REG_CTRL && s_axi_wstrb[0] && s_axi_wdata[CTRL_START_BIT]
                    && q.count_cfg != 16'h0) begin
                    n.cs_n     = 1'b0;
                    n.idx      = '0;
                    n.remain   = q.count_cfg;
                    n.done_cnt = 16'h0;
                    n.cur_ch   = order_ch(q.seq_cfg, '0);
                    n          = launch(n, n.cur_ch);
                    n.changed  = 1'b1;
                    n.state    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!q.sh_busy && q.settle >= 5'(SETTLE_CYC)
                    && q.since >= (q.changed ? 8'(PACE_CHG_CYC) : 8'(PACE_SAME_CYC))) begin
                    n.conversion_start_n_n = 1'b0;
                    n.cnt      = 3'(CONVERSION_START_N_LOW_CYC - 1);
                    n.since    = 8'h00;
                    n.remain   = q.remain - 16'h1;
                    n.conv_ch  = q.cur_ch;
                    n.state    = ST_CONV;
                    nidx = (q.idx == q.seq_cfg[SEQ_LEN_LSB +: CH_BITS]) ? '0 : q.idx + 3'h1;
                    nch  = order_ch(q.seq_cfg, nidx);
                    n.idx = nidx;
                    n.changed = 1'b0;
                    // Reselect during the conversion only when the channel differs.
                    if (q.remain != 16'h1 && nch != q.cur_ch) begin
                        n         = launch(n, nch);
                        n.changed = 1'b1;
                    end
                    n.cur_ch = nch;
                end
            end
            ST_CONV: begin
                if (q.cnt != 3'h0) begin
                    n.cnt = q.cnt - 3'h1;
                end else begin
                    n.conversion_start_n_n = 1'b1;
                end
                if (q.conversion_start_n_n && busy_rise) begin
                    n.rd_n  = 1'b0;
                    n.cnt   = 3'(RD_LOW_CYC - 1);
                    n.state = ST_READ;
                end
            end
            ST_READ: begin
                if (q.cnt != 3'h0) begin
                    n.cnt = q.cnt - 3'h1;
                end else begin
                    n.rd_n     = 1'b1;
                    n.data     = q.d2; // Data settled before busy rose.
                    n.data_ch  = q.conv_ch;
                    n.done_cnt = q.done_cnt + 16'h1;
                    set_ev[IRQ_SAMPLE_BIT] = 1'b1;
                    if (q.remain == 16'h0) begin
                        n.cs_n  = 1'b1;
                        set_ev[IRQ_DONE_BIT] = 1'b1;
                        n.state = ST_IDLE;
                    end else begin
                        n.state = ST_WAIT;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        // Write channel of the register slave.
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            case (wa)
                REG_SEQ: begin
                    n.seq_cfg = SEQ_WIDTH'(apply_strb(32'(q.seq_cfg), s_axi_wdata, s_axi_wstrb));
                end
                REG_COUNT: begin
                    n.count_cfg = 16'(apply_strb(32'(q.count_cfg), s_axi_wdata, s_axi_wstrb));
                end
                REG_IRQ_EN: begin
                    n.irq_en = IRQ_BITS'(apply_strb(32'(q.irq_en), s_axi_wdata, s_axi_wstrb));
                end
                REG_IRQ_CLR: begin
                    n.irq_st = q.irq_st & ~merged[IRQ_BITS-1:0];
                end
                REG_CTRL, REG_STATUS, REG_DATA, REG_IRQ_ST: begin
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        n.irq_st = n.irq_st | set_ev;
        // Read channel of the register slave.
        case (ra)
            REG_CTRL:    rword = 32'h0;
            REG_SEQ:     rword = 32'(q.seq_cfg);
            REG_COUNT:   rword = 32'(q.count_cfg);
            REG_STATUS: begin
                rword[0] = (q.state != ST_IDLE);
                rword[STAT_SHIFT_BIT] = q.sh_busy;
                rword[STAT_CH_LSB +: CH_BITS] = q.conv_ch;
                rword[STAT_CNT_LSB +: 16] = q.done_cnt;
            end
            REG_DATA: begin
                rword[DATA_BITS-1:0] = q.data;
                rword[DATA_CH_LSB +: CH_BITS] = q.data_ch;
            end
            REG_IRQ_ST:  rword = 32'(q.irq_st);
            REG_IRQ_EN:  rword = 32'(q.irq_en);
            default:     rword = 32'h0;
        endcase
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            n.rvalid = 1'b1;
            n.rdata  = rword;
            n.rresp  = (ra == REG_IRQ_CLR || ra > REG_IRQ_CLR) ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // State register with synchronous reset to idle pin levels.
    always_ff @(posedge clock) begin
        if (rst) begin
            q          <= '0;
            q.state    <= ST_IDLE;
            q.cs_n     <= 1'b1;
            q.conversion_start_n_n <= 1'b1;
            q.rd_n     <= 1'b1;
            q.settle   <= 5'h1f;
            q.since    <= 8'hff;
            q.seq_cfg  <= SEQ_RESET;
            {q.b1, q.b2, q.b3} <= 3'h7; // Idle busy level, so no false edge follows reset.
        end else begin
            q <= n;
        end
    end

    // Helper counters read only by the checks below.
    logic [4:0] h_sel_low;
    logic [7:0] h_gap;
    logic [2:0] h_edges;
    logic       h_conversion_start_n;
    logic       h_sclk;
    always_ff @(posedge clock) begin
        if (rst) begin
            h_sel_low <= 5'h1f;
            h_gap     <= 8'hff;
            h_edges   <= 3'h0;
            h_conversion_start_n  <= 1'b1;
            h_sclk    <= 1'b0;
        end else begin
            h_conversion_start_n  <= conversion_start_n;
            h_sclk    <= mux_sclk;
            h_sel_low <= mux_select_n ? 5'h00 : ((h_sel_low == 5'h1f) ? h_sel_low : h_sel_low + 5'h01);
            h_gap     <= (!conversion_start_n && h_conversion_start_n) ? 8'h01
                       : ((h_gap == 8'hff) ? h_gap : h_gap + 8'h01);
            h_edges   <= !mux_select_n ? 3'h0 : h_edges + 3'(mux_sclk && !h_sclk);
        end
    end

    sequence busy_edge_s;
        q.state == ST_CONV && q.conversion_start_n_n && busy_rise;
    endsequence
    sequence read_window_s;
        (!adc_rd_n)[*4] ##1 adc_rd_n;
    endsequence

    AST_SHIFT_UNDER_SELECT: assert property (@(posedge clock) disable iff (rst)
        $rose(mux_sclk) |-> mux_select_n) else $error("Serial clock rose with mux select low.");
    AST_LATCH_AFTER_WORD: assert property (@(posedge clock) disable iff (rst)
        $fell(mux_select_n) |-> h_edges == 3'(SEL_BITS)) else $error("Select fell before full word.");
    AST_SETTLE_BEFORE_START: assert property (@(posedge clock) disable iff (rst)
        $fell(conversion_start_n) |-> h_sel_low >= 5'(SETTLE_CYC)) else $error("Mux settle time short.");
    AST_PIPELINE_SHIFT: assert property (@(posedge clock) disable iff (rst)
        $rose(mux_select_n) && !$past(adc_cs_n) |-> $fell(conversion_start_n))
        else $error("Reselection not overlapped with conversion.");
    AST_CS_HELD: assert property (@(posedge clock) disable iff (rst)
        $fell(conversion_start_n) |-> (!adc_cs_n)[*8]) else $error("Chip select released mid series.");
    AST_READ_STROBE: assert property (@(posedge clock) disable iff (rst)
        $fell(adc_rd_n) |-> read_window_s) else $error("Read strobe width wrong.");
    AST_BUSY_TRIGGERS_READ: assert property (@(posedge clock) disable iff (rst)
        busy_edge_s |=> !adc_rd_n && q.state == ST_READ) else $error("Busy edge did not start read.");
    AST_RATE_CHANGED: assert property (@(posedge clock) disable iff (rst)
        $fell(conversion_start_n) && $past(q.changed) |-> h_gap >= 8'(PACE_CHG_CYC))
        else $error("Conversions too close after channel change.");
    AST_RATE_SAME: assert property (@(posedge clock) disable iff (rst)
        $fell(conversion_start_n) |-> h_gap >= 8'(PACE_SAME_CYC)) else $error("Conversions too close.");
endmodule

// file: test/dmas_front_model.sv
// Behavioural model of the two serial multiplexers and the sampling converter.
// Assumes the controller drives the shared mux pins and the converter's start, select and read.
`timescale 1ns/1ps

module dmas_front_model
    import dmas_pkg::*;
(
    input  wire logic                 mux_select_n,
    input  wire logic                 mux_sclk,
    input  wire logic                 mux_data,
    input  wire logic                 conversion_start_n,
    input  wire logic                 adc_cs_n,
    input  wire logic                 adc_rd_n,
    output logic                      adc_busy,
    output logic [DATA_BITS-1:0]      adc_data,
    output logic [7:0]                viol,
    output logic [7:0]                shifts,
    output logic [23:0]               ch_log
);
    logic [SEL_BITS-1:0]  sh_reg  = '0;
    logic [SEL_BITS-1:0]  sel_reg = '0;
    logic [DATA_BITS-1:0] res_reg = '0;
    logic [2:0]           prev_ch = '0;
    realtime              t_sel   = 0.0;
    realtime              t_conv  = -1.0e6;
    int                   nbits   = 0;

    initial begin
        adc_busy = 1'b1;
        viol = '0;
        shifts = '0;
        ch_log = '0;
    end

    // Both multiplexers take the same bit on each serial clock rise while selected.
    always @(posedge mux_sclk) begin
        if (mux_select_n) begin
            sh_reg <= {sh_reg[SEL_BITS-2:0], mux_data};
            nbits = nbits + 1;
        end
    end

    // The falling select latches the shifted word; a fall with no bits shifted is not a latch.
    always @(negedge mux_select_n) begin
        if (nbits != 0) begin
            if (nbits != SEL_BITS) viol = viol + 1;
            sel_reg = sh_reg;
            t_sel = $realtime;
            shifts = shifts + 1;
        end
        nbits = 0;
    end

    // A start fall samples the chosen pair and converts; settling and pacing faults are counted.
    always @(negedge conversion_start_n) begin
        if (adc_cs_n || !sel_reg[3] || $realtime - t_sel < 700.0) viol = viol + 1;
        if ($realtime - t_conv < ((sel_reg[2:0] != prev_ch) ? 1600.0 : 800.0)) viol = viol + 1;
        t_conv = $realtime;
        prev_ch = sel_reg[2:0];
        ch_log = {ch_log[20:0], sel_reg[2:0]};
        adc_busy = 1'b0;
        #600;
        res_reg = {prev_ch, 9'h15a};
        #20;
        adc_busy = 1'b1;
    end

    // A read strobe without chip select is a fault of the controller.
    always @(negedge adc_rd_n) begin
        if (adc_cs_n) viol = viol + 1;
    end

    // Drivers are on only under the read strobe; otherwise the bus shows the inverse.
    assign adc_data = (!adc_rd_n && !adc_cs_n) ? res_reg : ~res_reg;
endmodule

// file: test/dmas_ctrl_tb.sv
// Self-checking bench for the sequencer controller, driven over its AXI4-Lite registers.
// Assumes the front-end model stands on the pin side and answers every conversion.
`timescale 1ns/1ps

module dmas_ctrl_tb
    import dmas_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd_val;
    logic mux_select_n, mux_sclk, mux_data, conversion_start_n, adc_cs_n, adc_rd_n;
    logic adc_busy, irq;
    logic [DATA_BITS-1:0] adc_data;
    logic [7:0] viol, shifts;
    logic [23:0] ch_log;
    int errors = 0;
    int check_count = 0;

    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    dmas_ctrl uut (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mux_select_n(mux_select_n),
        .mux_sclk(mux_sclk), .mux_data(mux_data), .conversion_start_n(conversion_start_n),
        .adc_cs_n(adc_cs_n), .adc_rd_n(adc_rd_n), .adc_busy(adc_busy), .adc_data(adc_data),
        .irq(irq));

    dmas_front_model model (.mux_select_n(mux_select_n), .mux_sclk(mux_sclk),
        .mux_data(mux_data), .conversion_start_n(conversion_start_n), .adc_cs_n(adc_cs_n),
        .adc_rd_n(adc_rd_n), .adc_busy(adc_busy), .adc_data(adc_data), .viol(viol),
        .shifts(shifts), .ch_log(ch_log));

    // Prints the counts and the verdict, then ends the run.
    task finish_test();
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Compares one value with its expectation and counts the outcome.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits, bounded, for a handshake; inputs are steady from the falling edge to the next rise.
    task wait_sig(input int which);
        int n;
        logic ok;
        n = 0;
        do begin
            @(negedge clock);
            case (which)
                0: ok = s_axi_awready && s_axi_wready;
                1: ok = s_axi_bvalid;
                2: ok = s_axi_arready;
                default: ok = s_axi_rvalid;
            endcase
            rsp = (which == 1) ? s_axi_bresp : s_axi_rresp;
            rd_val = s_axi_rdata;
            @(posedge clock);
            n++;
        end while (ok !== 1'b1 && n < 400);
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t: handshake timeout", $time);
            finish_test();
        end
    endtask

    // One register write; entered just after a rising edge.
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        wait_sig(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        wait_sig(1);
    endtask

    // One register read; the word lands in rd_val and the response in rsp.
    task axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        wait_sig(2);
        s_axi_arvalid <= 1'b0;
        wait_sig(3);
    endtask

    // Polls the interrupt status until the series-done bit is set.
    task wait_done();
        int n;
        n = 0;
        do begin
            axi_rd(REG_IRQ_ST);
            n++;
        end while (rd_val[IRQ_DONE_BIT] !== 1'b1 && n < 200);
        check(rd_val[IRQ_DONE_BIT], 1);
        if (rd_val[IRQ_DONE_BIT] !== 1'b1) finish_test();
    endtask

    // Runs one series: order list, conversion count, start.
    task run_series(input logic [31:0] seq, input logic [15:0] cnt);
        axi_wr(REG_SEQ, seq);
        axi_wr(REG_COUNT, {16'h0, cnt});
        axi_wr(REG_CTRL, 32'h1);
        wait_done();
    endtask

    // Main sequence: reset and map, a changing-channel series, interrupts, a same-channel series.
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({mux_select_n, mux_sclk, adc_cs_n, conversion_start_n, adc_rd_n}, 32'h7);
        axi_rd(REG_SEQ);
        check(rd_val, {5'h0, SEQ_RESET});
        axi_rd(REG_COUNT);
        check(rd_val, 32'h0);
        axi_rd(REG_IRQ_EN);
        check(rd_val, 32'h0);
        axi_rd(8'h20);
        check(rsp, RESP_SLVERR);
        axi_rd(REG_IRQ_CLR);
        check(rsp, RESP_SLVERR);
        axi_wr(8'h20, 32'h1);
        check(rsp, RESP_SLVERR);
        $display("Test reset and map done");
        run_series(32'h01000015, 16'd3);
        check(ch_log[8:0], {3'd5, 3'd2, 3'd5});
        check(shifts, 32'd3);
        check(adc_cs_n, 1);
        check(irq, 0);
        axi_rd(REG_IRQ_ST);
        check(rd_val, 32'h3);
        axi_rd(REG_DATA);
        check(rd_val, {13'h0, 3'd5, 4'h0, 3'd5, 9'h15a});
        axi_rd(REG_STATUS);
        check(rd_val, {16'd3, 9'h0, 3'd5, 4'h0});
        axi_wr(REG_IRQ_EN, 32'h2);
        check(rsp, RESP_OKAY);
        check(irq, 1);
        axi_wr(REG_IRQ_CLR, 32'h2);
        check(irq, 0);
        axi_rd(REG_IRQ_ST);
        check(rd_val, 32'h1);
        $display("Test changing channels and interrupts done");
        run_series(32'h00000003, 16'd2);
        check(ch_log[5:0], {3'd3, 3'd3});
        check(shifts, 32'd4);
        check(irq, 1);
        axi_rd(REG_DATA);
        check(rd_val, {13'h0, 3'd3, 4'h0, 3'd3, 9'h15a});
        axi_rd(REG_STATUS);
        check(rd_val, {16'd2, 9'h0, 3'd3, 4'h0});
        check(viol, 32'd0);
        $display("Test same channel done");
        finish_test();
    end
endmodule
